// ==== src/pdmcap_pkg.sv ====
// Shared constants and carrier types for the microphone capture block
package pdmcap_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_TASK_START  = 12'h000;
  localparam logic [11:0] OFF_TASK_STOP   = 12'h004;
  localparam logic [11:0] OFF_EVT_STARTED = 12'h100;
  localparam logic [11:0] OFF_EVT_STOPPED = 12'h104;
  localparam logic [11:0] OFF_EVT_END     = 12'h108;
  localparam logic [11:0] OFF_CLK_CTRL    = 12'h504;
  localparam logic [11:0] OFF_MODE        = 12'h508;
  localparam logic [11:0] OFF_PTR         = 12'h560;
  localparam logic [11:0] OFF_MAXCNT      = 12'h564;
  localparam logic [11:0] OFF_STATUS      = 12'h600;

  // ==========================================================
  // Field positions and widths
  localparam int          MODE_MONO_BIT = 0;
  localparam int          MODE_SWAP_BIT = 1;
  localparam int          BIT_CLOCK_FREQUENCY_FIELD_W        = 8;
  localparam int          MAXCNT_W      = 15;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_BIT_CLOCK_FREQUENCY_FIELD      = 8'h31;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic [31:0] RST_PTR       = 32'h0000_0000;
  localparam logic [14:0] RST_MAXCNT    = 15'h0000;

  // ==========================================================
  // Filter figures
  localparam int          DEC_RATIO     = 64;
  localparam int          PCM_W         = 16;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } pdmcap_dma_t;

  typedef struct packed {
    logic swap;
    logic mono;
  } pdmcap_mode_t;

endpackage : pdmcap_pkg

// ==== src/pdmcap_decim.sv ====
// Second-order CIC decimator turning one density bitstream into PCM
`timescale 1ns/100ps
module pdmcap_decim #(
  parameter int RATIO = pdmcap_pkg::DEC_RATIO,
  parameter int OUT_W = pdmcap_pkg::PCM_W
) (
  // Clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             clear_i,
  // Bit input
  input  wire logic             bit_vld_i,
  input  wire logic             bit_i,
  // Sample output
  output logic                  pcm_vld_o,
  output logic [OUT_W-1:0]      pcm_o
);
  localparam int AW = 2 * $clog2(RATIO) + 2;
  localparam int CW = $clog2(RATIO);

  logic [AW-1:0] int1_q, int2_q, dly1_q, dly2_q;
  logic [CW-1:0] cnt_q;
  logic [AW-1:0] comb1, comb2, centred;
  logic          last;

  // ==========================================================
  // Comb stage, evaluated once per decimation period
  assign last    = (cnt_q == CW'(RATIO - 1));
  assign comb1   = int2_q - dly1_q;
  assign comb2   = comb1 - dly2_q;
  // Full-scale ones gives RATIO^2; centre it on zero
  assign centred = comb2 - AW'(RATIO * RATIO / 2);

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clear_i)) begin
      int1_q    <= '0;
      int2_q    <= '0;
      dly1_q    <= '0;
      dly2_q    <= '0;
      cnt_q     <= '0;
      pcm_vld_o <= 1'b0;
      pcm_o     <= '0;
    end else if (ce_i) begin
      pcm_vld_o <= 1'b0;
      if (bit_vld_i) begin
        int1_q <= int1_q + AW'(bit_i);
        int2_q <= int2_q + int1_q;
        cnt_q  <= cnt_q + CW'(1);
        if (last) begin
          dly1_q    <= int2_q;
          dly2_q    <= comb1;
          pcm_vld_o <= 1'b1;
          // Positive full scale would wrap, so clamp it
          if (comb2 >= AW'(RATIO * RATIO))
            pcm_o <= {1'b0, {(OUT_W-1){1'b1}}};
          else
            pcm_o <= OUT_W'(centred << (OUT_W - 2 * CW));
        end
      end
    end
  end

endmodule : pdmcap_decim

// ==== src/pdmcap_top.sv ====
// Microphone capture: bit clock, edge split, decimation, DMA writer, registers
`timescale 1ns/100ps

// Summary of operation
// - Drive bit clock, accept mono or stereo
// - Two microphones share one data line
// - Output 16-bit PCM at 16 kHz
// - Frequency field sets bit clock rate
// - Bit clock is clean divider of source
// - Default left on falling, right rising
// - Swap setting reverses capture edges
// - Own filter per channel, down-sampled
// - DMA writes samples into one buffer
// - Stereo alternates left/right; mono left only
// - Start task runs, stop task ends
// - Stop cuts bit clock at once, then halted
// - Halted only after final DMA write
// - One sample pair per 64 periods
// - Pointer double-buffered after buffer-begun
// - Full raises end, continues, begun again
// - Little endian, left low, right high
module pdmcap_top (
  // Clock, reset, enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [11:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Microphone pins
  output logic                          mic_bit_clock_o,
  input  wire logic                     mic_data_i,
  // DMA write port
  output logic                          dma_req_o,
  output pdmcap_pkg::pdmcap_dma_t       dma_o,
  input  wire logic                     dma_ack_i,
  // Event pulses
  output logic                          evt_started_o,
  output logic                          evt_end_o,
  output logic                          evt_stopped_o
);

  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} pdmcap_state_t;

  pdmcap_state_t state_q, state_d;

  logic [pdmcap_pkg::BIT_CLOCK_FREQUENCY_FIELD_W-1:0]   bit_clock_frequency_field_q, div_q;
  logic [pdmcap_pkg::MAXCNT_W-1:0] maxcnt_q, cnt_q;
  pdmcap_pkg::pdmcap_mode_t        mode_q, run_mode_q;
  logic [31:0]                     ptr_q, cur_ptr_q;
  logic                            ev_started_q, ev_stopped_q, ev_end_q;
  logic                            sync1_q, sync2_q;
  logic                            half_q;
  logic [15:0]                     left_q, right_q, mono_lo_q;
  logic                            left_rdy_q, right_rdy_q, mono_half_q;

  localparam pdmcap_pkg::pdmcap_mode_t RST_MODE_T = pdmcap_pkg::RST_MODE;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction : merge_sel

  // ==========================================================
  // Bus decode
  wire        bus_req   = wb_cyc_i && wb_stb_i;
  wire        wr_now    = bus_req && wb_we_i && wb_ack_o;
  wire        wr_start  = wr_now && (wb_adr_i == pdmcap_pkg::OFF_TASK_START) && wb_dat_i[0];
  wire        wr_stop   = wr_now && (wb_adr_i == pdmcap_pkg::OFF_TASK_STOP) && wb_dat_i[0];
  wire        wr_ev_st  = wr_now && (wb_adr_i == pdmcap_pkg::OFF_EVT_STARTED);
  wire        wr_ev_sp  = wr_now && (wb_adr_i == pdmcap_pkg::OFF_EVT_STOPPED);
  wire        wr_ev_end = wr_now && (wb_adr_i == pdmcap_pkg::OFF_EVT_END);
  wire        wr_bit_clock_frequency_field   = wr_now && (wb_adr_i == pdmcap_pkg::OFF_CLK_CTRL);
  wire        wr_mode   = wr_now && (wb_adr_i == pdmcap_pkg::OFF_MODE);
  wire        wr_ptr    = wr_now && (wb_adr_i == pdmcap_pkg::OFF_PTR);
  wire        wr_maxcnt = wr_now && (wb_adr_i == pdmcap_pkg::OFF_MAXCNT);
  wire [31:0] wdat_bit_clock_frequency_field = merge_sel(32'(bit_clock_frequency_field_q), wb_dat_i, wb_sel_i);
  wire [31:0] wdat_mode = merge_sel(32'(mode_q), wb_dat_i, wb_sel_i);
  wire [31:0] wdat_ptr  = merge_sel(ptr_q, wb_dat_i, wb_sel_i);
  wire [31:0] wdat_max  = merge_sel(32'(maxcnt_q), wb_dat_i, wb_sel_i);

  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      pdmcap_pkg::OFF_EVT_STARTED: rd_mux = 32'(ev_started_q);
      pdmcap_pkg::OFF_EVT_STOPPED: rd_mux = 32'(ev_stopped_q);
      pdmcap_pkg::OFF_EVT_END:     rd_mux = 32'(ev_end_q);
      pdmcap_pkg::OFF_CLK_CTRL:    rd_mux = 32'(bit_clock_frequency_field_q);
      pdmcap_pkg::OFF_MODE:        rd_mux = 32'(mode_q);
      pdmcap_pkg::OFF_PTR:         rd_mux = ptr_q;
      pdmcap_pkg::OFF_MAXCNT:      rd_mux = 32'(maxcnt_q);
      pdmcap_pkg::OFF_STATUS:      rd_mux = {29'h0, dma_req_o, state_q != ST_IDLE,
                                             state_q == ST_DRAIN};
      default:                     rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Wishbone answer: one wait state, ack one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_clock_frequency_field_q   <= pdmcap_pkg::RST_BIT_CLOCK_FREQUENCY_FIELD;
      mode_q   <= pdmcap_pkg::RST_MODE;
      ptr_q    <= pdmcap_pkg::RST_PTR;
      maxcnt_q <= pdmcap_pkg::RST_MAXCNT;
    end else if (ce_i) begin
      // Zero would wrap the divider compare to a 256-cycle half period, so keep at least one
      if (wr_bit_clock_frequency_field)
        bit_clock_frequency_field_q <= (wdat_bit_clock_frequency_field[7:0] == 8'h00) ? 8'h01 : wdat_bit_clock_frequency_field[7:0];
      if (wr_mode)
        mode_q <= wdat_mode[1:0];
      if (wr_ptr)
        ptr_q <= wdat_ptr;
      if (wr_maxcnt)
        maxcnt_q <= wdat_max[pdmcap_pkg::MAXCNT_W-1:0];
    end
  end

  // ==========================================================
  // Control state
  wire dma_done = dma_req_o && dma_ack_i;
  wire running  = (state_q == ST_RUN);
  wire word_pend;
  wire halt_now = (state_q == ST_DRAIN) && !dma_req_o && !word_pend;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (wr_start) state_d = ST_RUN;
      ST_RUN:   if (wr_stop) state_d = ST_DRAIN;
      ST_DRAIN: if (halt_now) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_q <= ST_IDLE;
    else if (ce_i)
      state_q <= state_d;
  end

  // ==========================================================
  // Bit clock divider from the system clock
  // Pure counter off the source edge: no added jitter beyond the source
  wire div_hit = (div_q >= bit_clock_frequency_field_q - 8'h01);
  wire tick    = running && div_hit;
  wire rise    = tick && !mic_bit_clock_o;
  wire fall    = tick && mic_bit_clock_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q           <= '0;
      mic_bit_clock_o <= 1'b0;
    end else if (ce_i) begin
      if (!running) begin
        div_q           <= '0;
        mic_bit_clock_o <= 1'b0;
      end else if (div_hit) begin
        div_q           <= '0;
        mic_bit_clock_o <= !mic_bit_clock_o;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // Pin synchroniser and edge split
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= mic_data_i;
      sync2_q <= sync1_q;
    end
  end

  // Both microphones drive the one line; edge picks the talker
  wire swap   = run_mode_q.swap;
  wire l_take = swap ? rise : fall;
  wire r_take = swap ? fall : rise;

  // ==========================================================
  // Per-channel decimators, one pair per 64 bit clocks
  wire        l_vld, r_vld;
  wire [15:0] l_pcm, r_pcm;
  wire        restart = wr_start && (state_q == ST_IDLE);

  pdmcap_decim #(.RATIO(pdmcap_pkg::DEC_RATIO), .OUT_W(pdmcap_pkg::PCM_W)) u_left (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .clear_i   (restart),
    .bit_vld_i (l_take),
    .bit_i     (sync2_q),
    .pcm_vld_o (l_vld),
    .pcm_o     (l_pcm)
  );

  pdmcap_decim #(.RATIO(pdmcap_pkg::DEC_RATIO), .OUT_W(pdmcap_pkg::PCM_W)) u_right (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .clear_i   (restart),
    .bit_vld_i (r_take),
    .bit_i     (sync2_q),
    .pcm_vld_o (r_vld),
    .pcm_o     (r_pcm)
  );

  // ==========================================================
  // Word assembly
  // Stereo: the channel that lands first waits for its partner of the
  // same period, whichever edge order is set; mono: two lefts per word
  wire        mono       = run_mode_q.mono;
  wire        st_word    = !mono && ((r_vld && left_rdy_q) || (l_vld && right_rdy_q));
  wire        mn_word    = mono && l_vld && mono_half_q;
  wire        word_vld   = running && (st_word || mn_word);
  wire [15:0] l_side     = l_vld ? l_pcm : left_q;
  wire [15:0] r_side     = r_vld ? r_pcm : right_q;
  wire [31:0] word_dat   = mono ? {l_pcm, mono_lo_q} : {r_side, l_side};
  // A filter output still on its way must be written before halting
  assign      word_pend  = l_vld || r_vld;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_q      <= 16'h0000;
      right_q     <= 16'h0000;
      left_rdy_q  <= 1'b0;
      right_rdy_q <= 1'b0;
      mono_lo_q   <= 16'h0000;
      mono_half_q <= 1'b0;
      run_mode_q  <= RST_MODE_T;
    end else if (ce_i) begin
      if (restart) begin
        run_mode_q  <= mode_q;
        left_rdy_q  <= 1'b0;
        right_rdy_q <= 1'b0;
        mono_half_q <= 1'b0;
      end else if (running) begin
        // Half a pair left at stop is dropped: its partner never comes
        if (!mono && l_vld) begin
          left_q      <= l_pcm;
          left_rdy_q  <= !right_rdy_q;
          right_rdy_q <= 1'b0;
        end else if (!mono && r_vld) begin
          right_q     <= r_pcm;
          right_rdy_q <= !left_rdy_q;
          left_rdy_q  <= 1'b0;
        end
        if (mono && l_vld) begin
          mono_lo_q   <= l_pcm;
          mono_half_q <= !mono_half_q;
        end
      end
    end
  end

  // ==========================================================
  // DMA writer with double-buffered pointer
  // No queue: a word that meets a busy port is dropped, the memory
  // side must accept one word well inside one sample period
  wire [pdmcap_pkg::MAXCNT_W-1:0] cnt_next = cnt_q + 15'h0002;
  wire full  = dma_done && (cnt_q >= maxcnt_q);
  wire take  = (word_vld || ((st_word || mn_word) && state_q == ST_DRAIN)) && !dma_req_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_req_o <= 1'b0;
      dma_o     <= '0;
      cnt_q     <= '0;
      cur_ptr_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (restart) begin
        cur_ptr_q <= ptr_q;
        cnt_q     <= '0;
      end else if (take) begin
        dma_req_o  <= 1'b1;
        dma_o.addr <= cur_ptr_q + 32'({cnt_q, 1'b0});
        dma_o.data <= word_dat;
        cnt_q      <= cnt_next;
      end else if (dma_done) begin
        dma_req_o <= 1'b0;
        if (full) begin
          cur_ptr_q <= ptr_q;
          cnt_q     <= '0;
        end
      end
    end
  end

  // ==========================================================
  // Events: hardware set wins over a software clear
  wire set_started = restart || (full && state_q == ST_RUN);
  wire set_stopped = halt_now;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_started_q  <= 1'b0;
      ev_stopped_q  <= 1'b0;
      ev_end_q      <= 1'b0;
      evt_started_o <= 1'b0;
      evt_end_o     <= 1'b0;
      evt_stopped_o <= 1'b0;
    end else if (ce_i) begin
      evt_started_o <= set_started;
      evt_end_o     <= full;
      evt_stopped_o <= set_stopped;
      if (set_started)
        ev_started_q <= 1'b1;
      else if (wr_ev_st && !wb_dat_i[0])
        ev_started_q <= 1'b0;
      if (set_stopped)
        ev_stopped_q <= 1'b1;
      else if (wr_ev_sp && !wb_dat_i[0])
        ev_stopped_q <= 1'b0;
      if (full)
        ev_end_q <= 1'b1;
      else if (wr_ev_end && !wb_dat_i[0])
        ev_end_q <= 1'b0;
    end
  end

endmodule : pdmcap_top

// ==== test/pdmcap_assertions.sv ====
// Port checker for the microphone capture block
`timescale 1ns/100ps
module pdmcap_chk (
  // Clock and register bus
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [11:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic                    wb_ack_o,
  // Pins, DMA and events
  input wire logic                    mic_bit_clock_o,
  input wire logic                    dma_req_o,
  input wire pdmcap_pkg::pdmcap_dma_t dma_o,
  input wire logic                    dma_ack_i,
  input wire logic                    evt_started_o,
  input wire logic                    evt_end_o,
  input wire logic                    evt_stopped_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire       st_w = wr & (wb_adr_i == pdmcap_pkg::OFF_TASK_START) & wb_dat_i[0];
  wire       sp_w = wr & (wb_adr_i == pdmcap_pkg::OFF_TASK_STOP) & wb_dat_i[0];
  wire       fq_w = wr & (wb_adr_i == pdmcap_pkg::OFF_CLK_CTRL) & wb_sel_i[0];
  logic      run_q, stp_q, tog_q, pv_q;
  logic [7:0] frq_q;
  int        cnt_q;
  wire       chg  = mic_bit_clock_o != pv_q;
  wire [7:0] eff  = (frq_q == 8'h00) ? 8'h01 : frq_q;
  // ==========================================================
  // Tracking of run state and bit clock spacing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frq_q <= pdmcap_pkg::RST_BIT_CLOCK_FREQUENCY_FIELD;
      {run_q, stp_q, tog_q, pv_q} <= 4'h0;
      cnt_q <= 0;
    end else if (ce_i) begin
      if (fq_w) frq_q <= wb_dat_i[7:0];
      run_q <= (run_q | st_w) & ~evt_stopped_o;
      stp_q <= (stp_q | sp_w) & ~evt_stopped_o & ~st_w;
      // First edge after start has no reference, so only later ones count
      tog_q <= (tog_q | chg) & run_q;
      pv_q  <= mic_bit_clock_o;
      cnt_q <= chg ? 1 : cnt_q + 1;
    end
  end
  // ==========================================================
  // Assertions
  idle_clock_a: assert property (!run_q |-> !mic_bit_clock_o)
    else $error("bit clock runs while idle");
  idle_dma_a: assert property (!run_q |-> !dma_req_o)
    else $error("DMA request while idle");
  start_event_a: assert property (st_w && !run_q |-> ##[1:3] evt_started_o)
    else $error("no started event after start");
  stop_bound_a: assert property (sp_w && run_q |-> ##[1:1000] evt_stopped_o)
    else $error("no stopped event after stop");
  dma_hold_a: assert property (dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_o))
    else $error("DMA request changed before accept");
  dma_drop_a: assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
    else $error("DMA request held after accept");
  end_pair_a: assert property (evt_end_o && !stp_q |->
                               evt_started_o && $past(dma_req_o && dma_ack_i))
    else $error("end event without final write and restart");
  stop_clean_a: assert property (evt_stopped_o |-> !dma_req_o && !mic_bit_clock_o)
    else $error("stopped event while still active");
  half_period_a: assert property (run_q && !stp_q && tog_q && chg |-> cnt_q == int'(eff))
    else $error("bit clock half period wrong");
endmodule : pdmcap_chk

bind pdmcap_top pdmcap_chk pdmcap_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .mic_bit_clock_o(mic_bit_clock_o), .dma_req_o(dma_req_o),
  .dma_o(dma_o), .dma_ack_i(dma_ack_i), .evt_started_o(evt_started_o),
  .evt_end_o(evt_end_o), .evt_stopped_o(evt_stopped_o));

// ==== test/pdmcap_mic_model.sv ====
// Two density microphones sharing one data line
`timescale 1ns/100ps
module pdmcap_mic_model (
  // Clocks
  input wire logic clk_i,
  input wire logic bclk_i,
  // Levels and fitting
  input wire logic l_bit_i,
  input wire logic r_bit_i,
  input wire logic r_fit_i,
  // Shared line
  output logic     data_o
);
  int   idle_n = 0;
  logic pb     = 1'b0;
  initial data_o = 1'b0;
  always @(posedge clk_i) begin
    idle_n = (bclk_i != pb) ? 0 : idle_n + 1;
    pb = bclk_i;
    // Mics sleep when the clock stops; a released line must not look stable
    if (idle_n > 64) data_o <= ~data_o;
    else if (bclk_i) data_o <= l_bit_i;
    else if (r_fit_i) data_o <= r_bit_i;
    else data_o <= ~data_o;
  end
endmodule : pdmcap_mic_model

// ==== test/tb.sv ====
// Self-checking bench for the microphone capture block
`timescale 1ns/100ps
module tb;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, ack = 0;
  logic [11:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0, rd;
  logic [15:0] lf = 16'h0033;
  logic [2:0]  wt = '0;
  logic [1:0]  mv = '0;
  logic        pclk = 0, preq = 0, end_due = 0;
  wire  [31:0] wb_dat;
  wire         wb_ack, bclk, mdat, req, e_st, e_end, e_sp;
  pdmcap_pkg::pdmcap_dma_t dma;
  int num_errors = 0, cmp_count = 0, cyc_n = 0, evc[3] = '{0, 0, 0};
  int rises = 0, base, ptr, idx, wpb = 1, seen = 0, exr;
  always #5 clk_i = ~clk_i;
  pdmcap_top pdmcap_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .mic_bit_clock_o(bclk), .mic_data_i(mdat),
    .dma_req_o(req), .dma_o(dma), .dma_ack_i(ack), .evt_started_o(e_st),
    .evt_end_o(e_end), .evt_stopped_o(e_sp));
  pdmcap_mic_model pdmcap_mic_model_i (.clk_i(clk_i), .bclk_i(bclk), .l_bit_i(1'b1),
    .r_bit_i(1'b0), .r_fit_i(~mv[0]), .data_o(mdat));
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
    rd = wb_dat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    cmp_val(rd, exp);
  endtask : rchk
  task automatic wait_ev(input int k, input int target, input int lim);
    int n;
    n = 0;
    while (evc[k] < target && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    cmp_flag(n < lim, 1'b1);
  endtask : wait_ev
  task automatic run_test(input logic [1:0] m, input logic [7:0] f, input int mc);
    int s0, e0;
    mv = m;
    wpb = mc / 2;
    exr = m[0] ? 128 : 64;
    seen = 0;
    idx = 0;
    lf = lfsr(lf);
    ptr = {14'h0800, lf, 2'b00};
    base = ptr;
    wb(1'b1, pdmcap_pkg::OFF_CLK_CTRL, {24'h0, f});
    wb(1'b1, pdmcap_pkg::OFF_MODE, {30'h0, m});
    wb(1'b1, pdmcap_pkg::OFF_PTR, ptr);
    wb(1'b1, pdmcap_pkg::OFF_MAXCNT, mc);
    {s0, e0} = {evc[0], evc[1]};
    wb(1'b1, pdmcap_pkg::OFF_TASK_START, 32'h1);
    for (int b = 1; b <= 2; b++) begin
      wait_ev(0, s0 + b, 200);
      lf = lfsr(lf);
      ptr = {14'h0800, lf, 2'b00};
      wb(1'b1, pdmcap_pkg::OFF_PTR, ptr);
      wait_ev(1, e0 + b, 20000);
    end
    rchk(pdmcap_pkg::OFF_EVT_STARTED, 32'h1);
    wb(1'b1, pdmcap_pkg::OFF_EVT_STARTED, 32'h0);
    rchk(pdmcap_pkg::OFF_EVT_STARTED, 32'h0);
    wb(1'b1, pdmcap_pkg::OFF_TASK_STOP, 32'h1);
    wait_ev(2, evc[2] + 1, 3000);
    repeat (50) @(posedge clk_i);
    $display("Test mode %0h bit_clock_frequency_field %0d done", m, f);
  endtask : run_test
  // ==========================================================
  // Memory side with random stalls, plus reference model
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 80000) begin
      num_errors++;
      close_out();
    end
    if (ack) ack <= 1'b0;
    else if (req && wt == 3'h0) begin
      ack <= 1'b1;
      lf = lfsr(lf);
      wt <= lf[2:0];
    end else if (req) wt <= wt - 3'h1;
    if (!rst_i) begin
      evc[0] += int'(e_st);
      evc[1] += int'(e_end);
      evc[2] += int'(e_sp);
      if (e_end || end_due) cmp_flag(e_end, end_due);
      end_due = 1'b0;
      if (bclk && !pclk) rises++;
      if (req && !preq && seen > 0) cmp_val(rises, exr);
      if (req && !preq) rises = 0;
      if (req && ack) begin
        cmp_val(dma.addr, base + 4 * idx);
        if (seen >= 3 && mv == 2'b00)
          cmp_flag($signed(dma.data[15:0]) > $signed(dma.data[31:16]), 1'b1);
        if (seen >= 3 && mv == 2'b10)
          cmp_flag($signed(dma.data[15:0]) < $signed(dma.data[31:16]), 1'b1);
        if (seen >= 3 && mv == 2'b01) cmp_val(dma.data[31:16], dma.data[15:0]);
        idx++;
        seen++;
        if (idx == wpb) begin
          end_due = 1'b1;
          idx = 0;
          base = ptr;
        end
      end
      {pclk, preq} = {bclk, req};
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(pdmcap_pkg::OFF_CLK_CTRL, {24'h0, pdmcap_pkg::RST_BIT_CLOCK_FREQUENCY_FIELD});
    rchk(pdmcap_pkg::OFF_MODE, {30'h0, pdmcap_pkg::RST_MODE});
    rchk(pdmcap_pkg::OFF_PTR, pdmcap_pkg::RST_PTR);
    rchk(pdmcap_pkg::OFF_MAXCNT, {17'h0, pdmcap_pkg::RST_MAXCNT});
    rchk(12'h7fc, 32'h0);
    $display("Test reset values done");
    run_test(2'b00, 8'h04, 8);
    run_test(2'b10, 8'h06, 6);
    run_test(2'b01, 8'h04, 4);
    close_out();
  end
endmodule : tb
